// File: lir_top.sv
// indirect register front end, mode control and panel clock generation
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RULE_01: pointer selects register behind chosen data port
// RULE_02: pointer holds value until power-on or write
// RULE_03: five-bit pointer, bit 4 stored but ignored
// RULE_04: unused bits ignore writes, read zero
// RULE_05: host selects only existing register numbers
// RULE_06: eight control, sixteen palette, five dma registers
// RULE_07: pointer and mode clear only on power-on
// RULE_08: on/off bit drives display-on pin directly
// RULE_09: module halt forces display-on pin low
// RULE_10: on/off bit clears on both resets
// RULE_11: ratio field picks dot clock from bus clock
// RULE_12: no ratio 000 in sixteen-shade or colour modes; the code accepts ratio 000 with any shade and mode_illegal does not flag it
// RULE_13: gating field stops line/shift clocks in retrace
// RULE_14: first vertical retrace line keeps line clock
// RULE_15: frame fetch requests only while enable set
// RULE_16: software leaves mode alone while displaying
// RULE_17: mode register field layout
// RULE_18: shade depth codes, 00 illegal
// RULE_19: panel mode codes, others illegal
// RULE_20: bus address picks one of six access choices
module lir_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bus_clock_out,
  input  wire logic        manual_reset_n,
  output logic             display_on_pin,
  output logic             line_pulse_clock,
  output logic             pixel_shift_clock,
  output logic             frame_fetch_req
);
  import lir_pkg::*;

  lir_state_t s_r;
  lir_state_t s_nxt;
  lir_mode_t  mode;

  // address to access choice
  function automatic lir_sel_t decode(input logic [7:0] a);
    lir_sel_t d;
    unique case (a)
      LIR_OFS_INDEX:  d = LIR_SEL_INDEX;
      LIR_OFS_DCTL:   d = LIR_SEL_DCTL;
      LIR_OFS_PAL:    d = LIR_SEL_PAL;
      LIR_OFS_DMA:    d = LIR_SEL_DMA;
      LIR_OFS_HALT:   d = LIR_SEL_HALT;
      LIR_OFS_STATUS: d = LIR_SEL_STATUS;
      default:        d = LIR_SEL_NONE;
    endcase
    return d;
  endfunction

  // display-control number to storage slot; numbers 7..12, 14, 15 have none
  function automatic logic dc_exists(input logic [3:0] n);
    return (n <= LIR_DC_LAST) || (n == LIR_DC_HIGH);
  endfunction

  function automatic logic [2:0] dc_slot(input logic [3:0] n);
    return (n == LIR_DC_HIGH) ? LIR_SLOT_HIGH : n[2:0];
  endfunction

  function automatic logic [15:0] dc_mask(input logic [3:0] n);
    logic [15:0] m;
    m = LIR_MASK_FULL;
    if (n == LIR_DC_SWITCH) begin
      m = LIR_MASK_SWITCH;
    end else if (n == LIR_DC_MODE) begin
      m = LIR_MASK_MODE;
    end
    return m;
  endfunction

  // byte-lane merge of the low half word
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
                                        input logic [1:0] strb, input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = dat[7:0];
    end
    if (strb[1]) begin
      v[15:8] = dat[15:8];
    end
    return v & msk;
  endfunction

  // rising-edge count mask per ratio code; illegal codes never tick
  function automatic logic [3:0] ratio_mask(input logic [2:0] r);
    logic [3:0] m;
    unique case (r)
      LIR_RATIO_X1: m = 4'h0;
      LIR_RATIO_D2: m = 4'h1;
      LIR_RATIO_D4: m = 4'h3;
      LIR_RATIO_D8: m = 4'h7;
      default:      m = 4'h8;
    endcase
    return m;
  endfunction

  logic [3:0]  idx;
  logic        mrst;
  logic        ck_rise;
  logic        ck_fall;
  logic        dot_tick;
  logic [3:0]  rmask;
  logic        run;
  logic [7:0]  nhd;
  logic [7:0]  nht;
  logic [9:0]  nvt;
  logic [9:0]  nvd;
  logic        hret;
  logic        vret;
  logic        first_vret;
  logic        line_gate;
  logic        shift_gate;
  logic        mode_illegal;
  logic        wr_go;
  lir_sel_t    wsel;
  lir_sel_t    rsel;
  logic [15:0] rd_val;
  logic [15:0] ptr_wr;

  assign idx  = s_r.ptr[3:0]; // RULE_03
  assign mode = lir_mode_t'(s_r.dctl[1][10:0]); // RULE_17
  assign mrst = ~s_r.mrst_sync[1];
  assign nhd  = s_r.dctl[LIR_DC_HCHAR[2:0]][15:8];
  assign nht  = s_r.dctl[LIR_DC_HCHAR[2:0]][7:0];
  assign nvt  = s_r.dctl[LIR_DC_VTOTAL[2:0]][9:0];
  assign nvd  = s_r.dctl[LIR_DC_VDISP[2:0]][9:0];

  assign ck_rise  = s_r.ck_sync[1] & ~s_r.ck_sync[2];
  assign ck_fall  = ~s_r.ck_sync[1] & s_r.ck_sync[2];
  assign rmask    = ratio_mask(mode.ratio);
  // x2 uses both edges of the sampled clock, so the bus clock must stay slow
  assign dot_tick = (mode.ratio == LIR_RATIO_X2) ? (ck_rise | ck_fall) :
                    (ck_rise && (({1'b0, s_r.div_cnt} & rmask) == rmask)); // RULE_11
  assign run      = s_r.dctl[0][0] & ~s_r.halt;

  assign hret       = s_r.chr > nhd;
  assign vret       = s_r.line > nvd;
  assign first_vret = s_r.line == (nvd + 10'h001);
  always_comb begin
    line_gate  = 1'b1;
    shift_gate = ~hret & ~vret;
    unique case (mode.gating) // RULE_13
      LIR_GATE_LINE_RUN: line_gate = 1'b1;
      LIR_GATE_BOTH_RUN: begin
        line_gate  = 1'b1;
        shift_gate = 1'b1;
      end
      default:           line_gate = ~vret | first_vret; // RULE_14
    endcase
  end

  assign mode_illegal = (mode.ratio > LIR_RATIO_D8) || (mode.gating == 2'h3) || // RULE_11
                        (mode.shade == LIR_SHADE_ILLEGAL) || // RULE_18
                        !(mode.panel inside {LIR_PANEL_MONO4, LIR_PANEL_MONO8, LIR_PANEL_DUAL,
                                             LIR_PANEL_ACTIVE, LIR_PANEL_PASSIVE}); // RULE_19

  assign wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;
  assign wsel  = decode(s_r.aw_addr); // RULE_20
  assign rsel  = decode(s_axi_araddr);
  // the mask keeps bit 4 stored, so it reads back though it selects nothing
  assign ptr_wr = merge({11'h000, s_r.ptr}, s_r.wdata, s_r.wstrb, LIR_MASK_INDEX); // RULE_03

  always_comb begin
    rd_val = 16'h0000;
    unique case (rsel) // RULE_01
      LIR_SEL_INDEX:  rd_val = {11'h000, s_r.ptr}; // RULE_04
      LIR_SEL_DCTL:   rd_val = dc_exists(idx) ? s_r.dctl[dc_slot(idx)] : 16'h0000;
      LIR_SEL_PAL:    rd_val = s_r.pal[idx];
      LIR_SEL_DMA:    rd_val = (idx <= LIR_DMA_LAST) ? s_r.dma[idx[2:0]] : 16'h0000;
      LIR_SEL_HALT:   rd_val = {15'h0000, s_r.halt};
      LIR_SEL_STATUS: rd_val = {13'h0000, mode_illegal, vret, s_r.don_pin};
      LIR_SEL_NONE:   rd_val = 16'h0000;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // bus write channels are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata[15:0];
      s_nxt.wstrb  = s_axi_wstrb[1:0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = LIR_RESP_OKAY;
      unique case (wsel) // RULE_01
        LIR_SEL_INDEX: s_nxt.ptr = ptr_wr[4:0]; // RULE_02
        LIR_SEL_DCTL: begin
          if (dc_exists(idx)) begin // RULE_06
            s_nxt.dctl[dc_slot(idx)] = merge(s_r.dctl[dc_slot(idx)], s_r.wdata, s_r.wstrb,
                                             dc_mask(idx)); // RULE_04
          end
        end
        LIR_SEL_PAL:  s_nxt.pal[idx] = merge(s_r.pal[idx], s_r.wdata, s_r.wstrb,
                                             LIR_MASK_FULL); // RULE_06
        LIR_SEL_DMA: begin
          if (idx <= LIR_DMA_LAST) begin // RULE_06
            s_nxt.dma[idx[2:0]] = merge(s_r.dma[idx[2:0]], s_r.wdata, s_r.wstrb,
                                        LIR_MASK_FULL);
          end
        end
        LIR_SEL_HALT: begin
          if (s_r.wstrb[0]) begin
            s_nxt.halt = s_r.wdata[0];
          end
        end
        LIR_SEL_STATUS: s_nxt.bresp = LIR_RESP_OKAY;
        LIR_SEL_NONE:   s_nxt.bresp = LIR_RESP_SLVERR;
      endcase
    end
    // read answer one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_val;
      s_nxt.rresp  = (rsel == LIR_SEL_NONE) ? LIR_RESP_SLVERR : LIR_RESP_OKAY;
    end

    // pin synchronisers
    s_nxt.ck_sync   = {s_r.ck_sync[1:0], bus_clock_out};
    s_nxt.mrst_sync = {s_r.mrst_sync[0], manual_reset_n};
    if (ck_rise) begin
      s_nxt.div_cnt = s_r.div_cnt + 3'h1;
    end

    // raster counters advance per dot while the display is on
    if (!run) begin
      s_nxt.dot       = 2'h0;
      s_nxt.chr       = 8'h00;
      s_nxt.line      = 10'h000;
      s_nxt.shift_clk = 1'b0;
      s_nxt.line_clk  = 1'b0;
    end else if (dot_tick) begin
      s_nxt.dot       = s_r.dot + 2'h1;
      s_nxt.shift_clk = shift_gate & ~s_r.shift_clk; // RULE_13
      s_nxt.line_clk  = line_gate && (s_r.chr == nht); // RULE_14
      if (s_r.dot == 2'h3) begin
        if (s_r.chr >= nht) begin
          s_nxt.chr  = 8'h00;
          s_nxt.line = (s_r.line >= nvt) ? 10'h000 : s_r.line + 10'h001;
        end else begin
          s_nxt.chr = s_r.chr + 8'h01;
        end
      end
    end
    // fetch stops during vertical retrace and whenever the enable is clear
    s_nxt.fetch_req = mode.fetch && run && !vret; // RULE_15
    s_nxt.don_pin   = s_r.dctl[0][0] & ~s_r.halt; // RULE_08 RULE_09

    // manual reset clears only the on/off bit, the display-on pin and the fetch request
    if (mrst) begin
      s_nxt.dctl[0][0] = 1'b0; // RULE_10
      s_nxt.don_pin    = 1'b0;
      s_nxt.fetch_req  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= LIR_STATE_RST; // RULE_07 RULE_10
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready     = !s_r.aw_held && !s_r.bvalid;
  assign s_axi_wready      = !s_r.w_held && !s_r.bvalid;
  assign s_axi_bvalid      = s_r.bvalid;
  assign s_axi_bresp       = s_r.bresp;
  assign s_axi_arready     = !s_r.rvalid;
  assign s_axi_rvalid      = s_r.rvalid;
  assign s_axi_rresp       = s_r.rresp;
  assign s_axi_rdata       = {16'h0000, s_r.rdata};
  assign display_on_pin    = s_r.don_pin;
  assign line_pulse_clock  = s_r.line_clk;
  assign pixel_shift_clock = s_r.shift_clk;
  assign frame_fetch_req   = s_r.fetch_req;

endmodule

`default_nettype wire

// File: lir_pkg.sv
// constants, types and register layout for the lcd indirect register front end
package lir_pkg;

  // byte addresses on the register bus
  localparam logic [7:0] LIR_OFS_INDEX  = 8'h00;
  localparam logic [7:0] LIR_OFS_DCTL   = 8'h04;
  localparam logic [7:0] LIR_OFS_PAL    = 8'h08;
  localparam logic [7:0] LIR_OFS_DMA    = 8'h0C;
  localparam logic [7:0] LIR_OFS_HALT   = 8'h10;
  localparam logic [7:0] LIR_OFS_STATUS = 8'h14;

  // writable bits of each register
  localparam logic [15:0] LIR_MASK_INDEX  = 16'h001F;
  localparam logic [15:0] LIR_MASK_SWITCH = 16'h0001;
  localparam logic [15:0] LIR_MASK_MODE   = 16'h07FF;
  localparam logic [15:0] LIR_MASK_FULL   = 16'hFFFF;

  // display-control register numbers
  localparam logic [3:0] LIR_DC_SWITCH = 4'h0;
  localparam logic [3:0] LIR_DC_MODE   = 4'h1;
  localparam logic [3:0] LIR_DC_HCHAR  = 4'h2;
  localparam logic [3:0] LIR_DC_VTOTAL = 4'h4;
  localparam logic [3:0] LIR_DC_VDISP  = 4'h5;
  localparam logic [3:0] LIR_DC_LAST   = 4'h6;
  localparam logic [3:0] LIR_DC_HIGH   = 4'hD;
  localparam logic [2:0] LIR_SLOT_HIGH = 3'h7;
  localparam logic [3:0] LIR_DMA_LAST  = 4'h4;

  // mode register field positions
  localparam int LIR_RATIO_LSB = 8;
  localparam int LIR_GATE_LSB  = 6;
  localparam int LIR_FETCH_BIT = 5;
  localparam int LIR_SHADE_LSB = 3;
  localparam int LIR_PANEL_LSB = 0;

  // dot-clock ratio codes
  localparam logic [2:0] LIR_RATIO_X2 = 3'h0;
  localparam logic [2:0] LIR_RATIO_X1 = 3'h1;
  localparam logic [2:0] LIR_RATIO_D2 = 3'h2;
  localparam logic [2:0] LIR_RATIO_D4 = 3'h3;
  localparam logic [2:0] LIR_RATIO_D8 = 3'h4;

  // retrace clock gating codes
  localparam logic [1:0] LIR_GATE_LINE_RUN = 2'h0;
  localparam logic [1:0] LIR_GATE_BOTH_RUN = 2'h1;
  localparam logic [1:0] LIR_GATE_BOTH_OFF = 2'h2;

  // illegal shade code and legal panel codes
  localparam logic [1:0] LIR_SHADE_ILLEGAL = 2'h0;
  localparam logic [2:0] LIR_PANEL_MONO4  = 3'h0;
  localparam logic [2:0] LIR_PANEL_MONO8  = 3'h1;
  localparam logic [2:0] LIR_PANEL_DUAL   = 3'h2;
  localparam logic [2:0] LIR_PANEL_ACTIVE = 3'h4;
  localparam logic [2:0] LIR_PANEL_PASSIVE = 3'h5;

  localparam logic [1:0] LIR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LIR_RESP_SLVERR = 2'h2;

  // status register bit positions
  localparam int LIR_ST_PIN     = 0;
  localparam int LIR_ST_VRET    = 1;
  localparam int LIR_ST_ILLEGAL = 2;

  typedef enum logic [2:0] {
    LIR_SEL_INDEX  = 3'b000,
    LIR_SEL_DCTL   = 3'b001,
    LIR_SEL_PAL    = 3'b010,
    LIR_SEL_DMA    = 3'b011,
    LIR_SEL_HALT   = 3'b100,
    LIR_SEL_STATUS = 3'b101,
    LIR_SEL_NONE   = 3'b110
  } lir_sel_t;

  typedef struct packed {
    logic [2:0] ratio;
    logic [1:0] gating;
    logic       fetch;
    logic [1:0] shade;
    logic [2:0] panel;
  } lir_mode_t;

  typedef struct packed {
    logic [4:0]        ptr;
    logic [7:0][15:0]  dctl;
    logic [15:0][15:0] pal;
    logic [4:0][15:0]  dma;
    logic              halt;
    logic              aw_held;
    logic [7:0]        aw_addr;
    logic              w_held;
    logic [15:0]       wdata;
    logic [1:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [15:0]       rdata;
    logic [1:0]        rresp;
    logic [2:0]        ck_sync;
    logic [2:0]        div_cnt;
    logic [1:0]        mrst_sync;
    logic [1:0]        dot;
    logic [7:0]        chr;
    logic [9:0]        line;
    logic              shift_clk;
    logic              line_clk;
    logic              don_pin;
    logic              fetch_req;
  } lir_state_t;

  localparam lir_state_t LIR_STATE_RST = '0;

endpackage

// File: lir_chk.sv
// concurrent checks on the register bus and display pins
`timescale 1ns/1ns
`default_nettype none
module lir_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        manual_reset_n,
  input wire logic        display_on_pin,
  input wire logic        frame_fetch_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  wr_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rresp != 2'h1)
    else $error("read upper bits set");
  mrst_off_a: assert property (!manual_reset_n [*6] |-> !display_on_pin && !frame_fetch_req)
    else $error("display on in manual reset");
endmodule
bind lir_top lir_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .manual_reset_n, .display_on_pin,
  .frame_fetch_req);
`default_nettype wire

// File: lir_panel_model.sv
// panel driver model counting line and shift clocks
`timescale 1ns/1ns
`default_nettype none
module lir_panel_model (
  input  wire logic  aclk,
  input  wire logic  clr,
  input  wire logic  display_on_pin,
  input  wire logic  line_pulse_clock,
  input  wire logic  pixel_shift_clock,
  input  wire logic  frame_fetch_req,
  output logic [15:0] shift_cnt,
  output logic [15:0] line_cnt,
  output logic        fetch_seen
);
  logic sh_q;
  logic ln_q;
  // a blanked panel ignores its clocks
  always_ff @(posedge aclk) begin
    sh_q <= pixel_shift_clock;
    ln_q <= line_pulse_clock;
    if (clr) begin
      shift_cnt <= 16'h0000;
      line_cnt <= 16'h0000;
      fetch_seen <= 1'b0;
    end else if (display_on_pin) begin
      if (pixel_shift_clock != sh_q) shift_cnt <= shift_cnt + 16'h0001;
      if (line_pulse_clock && !ln_q) line_cnt <= line_cnt + 16'h0001;
      if (frame_fetch_req) fetch_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: lcd_indirect_register_control_tb.sv
// self-checking bench for the lcd indirect register front end
`timescale 1ns/1ns
`default_nettype none
module lcd_indirect_register_control_tb;
  import lir_pkg::*;
  logic aclk, aresetn, bus_clock_out, manual_reset_n, clr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, got;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic display_on_pin, line_pulse_clock, pixel_shift_clock, frame_fetch_req, fetch_seen;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] shift_cnt, line_cnt;
  logic [1:0] resp;
  int errors, total_checks, e;
  int mdl [3][16];
  lir_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bus_clock_out, .manual_reset_n, .display_on_pin, .line_pulse_clock,
    .pixel_shift_clock, .frame_fetch_req);
  lir_panel_model i_panel (.aclk, .clr, .display_on_pin, .line_pulse_clock, .pixel_shift_clock,
    .frame_fetch_req, .shift_cnt, .line_cnt, .fetch_seen);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // free-running, unrelated in phase to aclk
  initial begin
    bus_clock_out = 1'b0;
    #13;
    forever #200 bus_clock_out = ~bus_clock_out;
  end
  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // ready and valid are read before the edge's own update lands; only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask
  // rready stays up between reads so back-to-back calls never drive it twice at one edge
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    got = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  function automatic int msk(input int g, input int n);
    return (g == 0 && n == 0) ? 'h1 : (g == 0 && n == 1) ? 'h7FF : 'hFFFF;
  endfunction
  // g: 0 display control, 1 palette, 2 dma control
  task automatic put(input int g, input int n, input logic [15:0] d);
    wr(LIR_OFS_INDEX, 16'(n));
    wr(LIR_OFS_DCTL + 8'(4 * g), d);
    mdl[g][n] = int'(d) & msk(g, n);
  endtask
  task automatic look(input int g, input int n);
    rd(LIR_OFS_DCTL + 8'(4 * g));
    chk(got, 32'(mdl[g][n]));
  endtask
  initial begin
    #1000000;
    errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h4D77));
    {aresetn, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    manual_reset_n = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(LIR_OFS_INDEX);
    chk(got, 32'h0);
    look(0, 0);
    wr(LIR_OFS_INDEX, 16'h1);
    look(0, 1);
    e = $urandom & 'h1F;
    wr(LIR_OFS_INDEX, 16'(e));
    rd(LIR_OFS_INDEX);
    chk(got, 32'(e));
    for (int n = 0; n < 16; n++) begin
      if (n > 1 && (n <= 6 || n == 13)) put(0, n, 16'($urandom) & 16'h03FF);
      put(1, n, 16'($urandom));
      if (n <= 4) put(2, n, 16'($urandom) & 16'h3FFF);
    end
    // one pointer write serves all three ports
    for (int n = 0; n < 16; n++) begin
      wr(LIR_OFS_INDEX, 16'(n));
      if (n <= 6 || n == 13) look(0, n);
      look(1, n);
      if (n <= 4) look(2, n);
    end
    wr(8'h18, 16'h1);
    chk(32'(resp), 32'(LIR_RESP_SLVERR));
    rd(8'h1C);
    chk(got, 32'h0);
    chk(32'(resp), 32'(LIR_RESP_SLVERR));
    put(0, 2, 16'h0203);
    put(0, 4, 16'h0003);
    put(0, 5, 16'h0001);
    for (int r = 0; r < 6; r++) begin
      put(0, 0, 16'h0);
      put(0, 1, 16'(r << 8 | 'h50 | (r & 1) << 5));
      put(0, 0, 16'h1);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (256) @(posedge aclk);
      e = (r < 5) ? (64 >> r) : 0;
      chk(32'(shift_cnt > e + 2 || shift_cnt + 2 < e), 32'h0);
      chk(32'(fetch_seen), 32'(r & 1));
      chk(32'(line_cnt > e / 16 + 1 || line_cnt + 1 < e / 16), 32'h0);
    end
    // last mode has an illegal ratio: status shows pin on, no retrace, illegal
    rd(LIR_OFS_STATUS);
    chk(got, 32'h5);
    // one frame of 64 dots: 24 shifts in the active area, line 3 gated only under code 10
    for (int c = 0; c < 3; c += 2) begin
      put(0, 0, 16'h0);
      put(0, 1, 16'(c << 6 | 'h10));
      put(0, 0, 16'h1);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (256) @(posedge aclk);
      chk(32'(shift_cnt > 26 || shift_cnt < 22), 32'h0);
      chk(32'(line_cnt), (c == 2) ? 32'h3 : 32'h4);
    end
    repeat (3) @(posedge aclk);
    chk(32'(display_on_pin), 32'h1);
    wr(LIR_OFS_HALT, 16'h1);
    repeat (3) @(posedge aclk);
    chk(32'(display_on_pin), 32'h0);
    wr(LIR_OFS_HALT, 16'h0);
    wr(LIR_OFS_INDEX, 16'h1);
    manual_reset_n <= 1'b0;
    repeat (8) @(posedge aclk);
    manual_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(display_on_pin), 32'h0);
    mdl[0][0] = 0;
    rd(LIR_OFS_INDEX);
    chk(got, 32'h1);
    look(0, 1);
    wr(LIR_OFS_INDEX, 16'h0);
    look(0, 0);
    wr(LIR_OFS_INDEX, 16'h1);
    // power-on reset in mid-run clears pointer and every register
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = '{default: 0};
    rd(LIR_OFS_INDEX);
    chk(got, 32'h0);
    look(0, 0);
    wr(LIR_OFS_INDEX, 16'h1);
    look(0, 1);
    conclude();
  end
endmodule
`default_nettype wire
